// ### ccm_top.sv
// Clock manager core: register port, input divider, 32-step delay line
// model, duty-cycle shaper and fast-edge output divider.
// Assumes clk_in is synchronous to mclk and far slower than it.
//
// Contract
// - Eight programmable registers at addresses zero-seven
// - Register 0: input divider value, reset bit
// - Register 1: feedback divider, PLL only
// - Register 2: output divider for fast-edge output
// - Register 3: doubler duty cycle selection
// - Register 4: delay or duty step
// - Register 5: loop mode and 1x select
// - Register 6: source status and output selects
// - Register 7: power, reset, configuration control
// - Outputs formed from 32 taps of period
// - DLL uses no feedback clock
// - Input divider divides by one to eight
// - Delayed clock steps of one thirty-second
// - Source 11 divides fast output only
// - Duty cycle in 3.125 percent steps
// - Steps 1-15 from bits 7:6 and 2:0
// - Steps 16-31 from bits 7:3
// - Write, read enables, 3-bit address, bytes
// - Lock asserts once output clock stable
`timescale 1ns/100ps
`default_nettype none
module ccm_top
#(
   parameter int PW = 16
)
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic clk_in,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [2:0] addr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata_q,
   output logic fast_edge_clock_output_q,
   output logic sys_clk_q,
   output logic lock_q
);

   logic [7:0] in_div_q;
   logic [7:0] out_div_q;
   logic [7:0] step_q;
   logic [7:0] mode_q;
   logic [7:0] src_q;
   logic [7:0] pwr_q;
   logic in_prev_q;
   logic ref_pulse;
   logic out_pulse;
   logic [PW-1:0] ph_q;
   logic [PW-1:0] period_q;
   logic active_q;
   logic dly_q;
   logic duty_q;
   logic div_out_q;
   logic [5:0] step;
   logic [PW+5:0] prod;
   logic [PW-1:0] thr;
   logic [PW-1:0] diff;
   logic delayed_d;
   logic duty_d;
   logic run;
   logic core_clr;
   logic [1:0] fast_sel;
   logic [1:0] sys_sel;

   // ***********************************
   // Register port
   // ***********************************
   ccm_regs u_regs
   (
      .mclk(mclk),
      .reset_n(reset_n),
      .ce(ce),
      .wr_en(wr_en),
      .rd_en(rd_en),
      .addr(addr),
      .wdata(wdata),
      .status({active_q, lock_q}),
      .rdata_q(rdata_q),
      .in_div_q(in_div_q),
      .out_div_q(out_div_q),
      .step_q(step_q),
      .mode_q(mode_q),
      .src_q(src_q),
      .pwr_q(pwr_q)
   );

   // Register 1 and 3 are stored only; no PLL or doubler path here
   // Software owns the mode bit; the core only follows it
   assign core_clr = pwr_q[ccm_pkg::PWR_RESET_BIT]
                     | pwr_q[ccm_pkg::PWR_DOWN_BIT];
   assign run = ~mode_q[ccm_pkg::MODE_PLL_BIT] & ~core_clr
                & (period_q != '0);
   assign fast_sel = src_q[ccm_pkg::SRC_FAST_LSB +: 2];
   assign sys_sel = src_q[ccm_pkg::SRC_SYS_LSB +: 2];

   // ***********************************
   // Input edge and input divider
   // ***********************************
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         in_prev_q <= 1'b0;
      end
      else if (ce)
      begin
         in_prev_q <= clk_in;
      end
   end

   ccm_div u_in_div
   (
      .mclk(mclk),
      .reset_n(reset_n),
      .ce(ce),
      .clr(in_div_q[ccm_pkg::DIV_RESET_BIT] | core_clr),
      .ratio_m1(in_div_q[ccm_pkg::DIV_RATIO_LSB +: 3]),
      .pulse_in(clk_in & ~in_prev_q),
      .pulse_q(ref_pulse)
   );

   // ***********************************
   // Period measurement and lock
   // ***********************************
   // Only the reference period is measured: no feedback path
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ph_q <= '0;
         period_q <= '0;
         lock_q <= 1'b0;
         active_q <= 1'b0;
      end
      else if (ce)
      begin
         if (core_clr)
         begin
            ph_q <= '0;
            period_q <= '0;
            lock_q <= 1'b0;
            active_q <= 1'b0;
         end
         else if (ref_pulse)
         begin
            ph_q <= '0;
            period_q <= ph_q + 1'b1;
            active_q <= 1'b1;
            // Two equal periods in a row count as a stable output
            // A saturated count wraps to zero and must never lock
            lock_q <= (ph_q + 1'b1 == period_q)
                      & (period_q != '0)
                      & ~mode_q[ccm_pkg::MODE_PLL_BIT];
         end
         else if (ph_q != '1)
         begin
            ph_q <= ph_q + 1'b1;
         end
         else
         begin
            // Stalled input clock drops lock and activity
            active_q <= 1'b0;
            lock_q <= 1'b0;
         end
         // Loop mode one has no DLL lock; measuring goes on
         if (mode_q[ccm_pkg::MODE_PLL_BIT])
         begin
            lock_q <= 1'b0;
         end
      end
   end

   // ***********************************
   // Tap decode and delay line model
   // ***********************************
   always_comb
   begin
      if (step_q[7] || step_q[6:3] == 4'hf)
      begin
         step = {1'b0, step_q[7:3]} + 6'h01;
      end
      else
      begin
         step = {1'b0, step_q[7:6], step_q[2:0]} + 6'h01;
      end
   end

   // Tap position is period times step over 32; accuracy is one mclk
   assign prod = {6'h00, period_q} * {{PW{1'b0}}, step};
   assign thr = prod[ccm_pkg::TAP_SHIFT +: PW];

   always_comb
   begin
      if (ph_q >= thr)
      begin
         diff = ph_q - thr;
      end
      else
      begin
         diff = ph_q + period_q - thr;
      end
      delayed_d = run & (diff < (period_q >> 1));
      duty_d = run & mode_q[ccm_pkg::MODE_DUTY_BIT] & (ph_q < thr);
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         dly_q <= 1'b0;
         duty_q <= 1'b0;
      end
      else if (ce)
      begin
         dly_q <= delayed_d;
         duty_q <= duty_d;
      end
   end

   // ***********************************
   // Fast-edge output divider
   // ***********************************
   ccm_div u_out_div
   (
      .mclk(mclk),
      .reset_n(reset_n),
      .ce(ce),
      .clr(out_div_q[ccm_pkg::DIV_RESET_BIT] | core_clr),
      .ratio_m1(out_div_q[ccm_pkg::DIV_RATIO_LSB +: 3]),
      .pulse_in(delayed_d & ~dly_q),
      .pulse_q(out_pulse)
   );

   // Divided output is high for one tap-clock high phase out of N
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         div_out_q <= 1'b0;
      end
      else if (ce)
      begin
         if (out_pulse)
         begin
            div_out_q <= 1'b1;
         end
         else if (!delayed_d && dly_q)
         begin
            div_out_q <= 1'b0;
         end
      end
   end

   // ***********************************
   // Output source selection
   // ***********************************
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         fast_edge_clock_output_q <= 1'b0;
      end
      else if (ce)
      begin
         case (fast_sel)
            ccm_pkg::SRC_DUTY: fast_edge_clock_output_q <= duty_q;
            ccm_pkg::SRC_DELAY: fast_edge_clock_output_q <= dly_q;
            ccm_pkg::SRC_DELAY_DIV: fast_edge_clock_output_q <= div_out_q;
            // Fast-edge pin picks duty, delayed or divided delayed
            default: fast_edge_clock_output_q <= 1'b0;
         endcase
      end
   end

   // Own flop per output keeps each pin glitch-free
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         sys_clk_q <= 1'b0;
      end
      else if (ce)
      begin
         // System output has no divided choice
         case (sys_sel)
            ccm_pkg::SRC_DUTY: sys_clk_q <= duty_q;
            ccm_pkg::SRC_DELAY: sys_clk_q <= dly_q;
            default: sys_clk_q <= 1'b0;
         endcase
      end
   end

endmodule
`default_nettype wire

// ### ccm_pkg.sv
// Constants shared by the clock manager register file, dividers and core.
// Assumes a single mclk domain; all users reference names as ccm_pkg::name.
package ccm_pkg;

   // ***********************************
   // Register addresses
   // ***********************************
   localparam logic [2:0] ADDR_INPUT_DIVIDER_CTRL = 3'h0;
   localparam logic [2:0] ADDR_FEEDBACK_DIVIDER_CTRL = 3'h1;
   localparam logic [2:0] ADDR_OUTPUT_DIVIDER_CTRL = 3'h2;
   localparam logic [2:0] ADDR_DOUBLER_DUTY_SELECT = 3'h3;
   localparam logic [2:0] ADDR_DELAY_DUTY_PHASE_SELECT = 3'h4;
   localparam logic [2:0] ADDR_LOOP_MODE_SELECT = 3'h5;
   localparam logic [2:0] ADDR_CLOCK_SOURCE_SELECT_STATUS = 3'h6;
   localparam logic [2:0] ADDR_MANAGER_POWER_RESET_CTRL = 3'h7;
   localparam int NUM_REGS = 8;

   // ***********************************
   // Field positions
   // ***********************************
   localparam int DIV_RATIO_LSB = 0;
   localparam int DIV_RESET_BIT = 7;
   localparam int MODE_PLL_BIT = 0;
   localparam int MODE_DUTY_BIT = 4;
   localparam int SRC_LOCK_BIT = 0;
   localparam int SRC_ACTIVE_BIT = 1;
   localparam int SRC_FAST_LSB = 4;
   localparam int SRC_SYS_LSB = 6;
   localparam int PWR_DOWN_BIT = 0;
   localparam int PWR_RESET_BIT = 1;

   // ***********************************
   // Output source codes and reset values
   // ***********************************
   localparam logic [1:0] SRC_OFF = 2'h0;
   localparam logic [1:0] SRC_DUTY = 2'h1;
   localparam logic [1:0] SRC_DELAY = 2'h2;
   localparam logic [1:0] SRC_DELAY_DIV = 2'h3;
   localparam logic [7:0] REG_RESET_VALUE = 8'h00;
   localparam int TAP_COUNT = 32;
   localparam int TAP_SHIFT = 5;

endpackage

// ### ccm_regs.sv
// Eight-byte register store of the clock manager with registered read data.
// Assumes write and read strobes synchronous to mclk.
`timescale 1ns/100ps
`default_nettype none
module ccm_regs
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [2:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [1:0] status,
   output logic [7:0] rdata_q,
   output logic [7:0] in_div_q,
   output logic [7:0] out_div_q,
   output logic [7:0] step_q,
   output logic [7:0] mode_q,
   output logic [7:0] src_q,
   output logic [7:0] pwr_q
);

   logic [7:0] mem_q [ccm_pkg::NUM_REGS];

   // ***********************************
   // Storage
   // ***********************************
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         for (int i = 0; i < ccm_pkg::NUM_REGS; i++)
         begin
            mem_q[i] <= ccm_pkg::REG_RESET_VALUE;
         end
      end
      else if (ce && wr_en)
      begin
         mem_q[addr] <= wdata;
      end
   end

   // ***********************************
   // Read port
   // ***********************************
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rdata_q <= ccm_pkg::REG_RESET_VALUE;
      end
      else if (ce && rd_en)
      begin
         if (addr == ccm_pkg::ADDR_CLOCK_SOURCE_SELECT_STATUS)
         begin
            rdata_q <= {mem_q[addr][7:2], status};
         end
         else
         begin
            rdata_q <= mem_q[addr];
         end
      end
   end

   assign in_div_q = mem_q[ccm_pkg::ADDR_INPUT_DIVIDER_CTRL];
   assign out_div_q = mem_q[ccm_pkg::ADDR_OUTPUT_DIVIDER_CTRL];
   assign step_q = mem_q[ccm_pkg::ADDR_DELAY_DUTY_PHASE_SELECT];
   assign mode_q = mem_q[ccm_pkg::ADDR_LOOP_MODE_SELECT];
   assign src_q = mem_q[ccm_pkg::ADDR_CLOCK_SOURCE_SELECT_STATUS];
   assign pwr_q = mem_q[ccm_pkg::ADDR_MANAGER_POWER_RESET_CTRL];

endmodule
`default_nettype wire

// ### ccm_div.sv
// Integer edge divider, ratio 1 to 8, emitting one pulse per N input pulses.
// Assumes pulse_in is a one-cycle edge marker in the mclk domain.
`timescale 1ns/100ps
`default_nettype none
module ccm_div
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic clr,
   input wire logic [2:0] ratio_m1,
   input wire logic pulse_in,
   output logic pulse_q
);

   logic [2:0] count_q;

   // ***********************************
   // Counter
   // ***********************************
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         count_q <= 3'h0;
         pulse_q <= 1'b0;
      end
      else if (ce)
      begin
         if (clr)
         begin
            count_q <= 3'h0;
            pulse_q <= 1'b0;
         end
         else if (pulse_in && count_q >= ratio_m1)
         begin
            count_q <= 3'h0;
            pulse_q <= 1'b1;
         end
         else
         begin
            count_q <= pulse_in ? count_q + 3'h1 : count_q;
            pulse_q <= 1'b0;
         end
      end
   end

endmodule
`default_nettype wire

// ### ccm_top_monitor.sv
// Port checker for the clock manager top.
// Assumes one mclk domain; bound to ccm_top.
`timescale 1ns/100ps
`default_nettype none
module ccm_top_monitor
#(
   parameter int PW = 16
)
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic clk_in,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [2:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata_q,
   input wire logic fast_edge_clock_output_q,
   input wire logic sys_clk_q,
   input wire logic lock_q
);
   // ****
   // Shadow state
   // ****
   logic [7:0] regs_q [8];
   logic [15:0] idle_q;
   logic [1:0] edges_q;
   logic clk_d1_q;
   logic [7:0] msk;
   logic [7:0] exp_rd;
   logic pll;
   logic sys_off;
   // Status bits come from the core, not the store
   assign msk = (addr == 3'h6) ? 8'hfc : 8'hff;
   assign exp_rd = regs_q[addr] & msk;
   assign pll = regs_q[5][0];
   assign sys_off = regs_q[6][7] == regs_q[6][6];
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         regs_q <= '{default: 8'h00};
      else if (ce && wr_en)
         regs_q[addr] <= wdata;
   end
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         idle_q <= 16'h0000;
         edges_q <= 2'h0;
         clk_d1_q <= 1'b0;
      end
      else
      begin
         clk_d1_q <= clk_in;
         idle_q <= (clk_in != clk_d1_q) ? 16'h0000 :
            (idle_q == 16'hffff) ? idle_q : idle_q + 16'h0001;
         if (clk_in && !clk_d1_q && edges_q != 2'h3)
            edges_q <= edges_q + 2'h1;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   chk_read_data: assert property (
      ce && rd_en |=> (rdata_q & $past(msk)) == $past(exp_rd))
      else $error("read data differs from stored byte");
   chk_read_holds: assert property (
      ce && !rd_en |=> $stable(rdata_q))
      else $error("read data moved without a read");
   chk_ce_freeze: assert property (
      !ce |=> $stable(rdata_q) && $stable(lock_q) && $stable(sys_clk_q))
      else $error("outputs moved while clock enable low");
   chk_status_lock: assert property (
      ce && rd_en && addr == 3'h6 |=> rdata_q[0] == $past(lock_q))
      else $error("status bit differs from lock");
   chk_pll_quiet: assert property (
      pll && $past(pll, 4) |-> !lock_q && !sys_clk_q
         && !fast_edge_clock_output_q)
      else $error("output active in loop mode one");
   chk_sys_off: assert property (
      sys_off && $past(sys_off, 4) |-> !sys_clk_q)
      else $error("system clock active while deselected");
   chk_lock_stops: assert property (
      idle_q > (1 << PW) + 200 |-> !lock_q)
      else $error("lock held with input clock stopped");
   chk_lock_late: assert property (
      $rose(lock_q) |-> edges_q == 2'h3)
      else $error("lock rose before three input edges");
endmodule
bind ccm_top ccm_top_monitor #(.PW(PW)) ccm_top_monitor_inst (.mclk(mclk),
   .reset_n(reset_n), .ce(ce), .clk_in(clk_in), .wr_en(wr_en),
   .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata_q(rdata_q),
   .fast_edge_clock_output_q(fast_edge_clock_output_q),
   .sys_clk_q(sys_clk_q), .lock_q(lock_q));
`default_nettype wire

// ### ccm_clk_src.sv
// Far-side user logic making the input clock to be conditioned.
// Assumes mclk domain; the clock stands low while disabled.
`timescale 1ns/100ps
`default_nettype none
module ccm_clk_src
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic en,
   input wire logic [7:0] half,
   output logic clk_in
);
   logic [7:0] cnt_q;
   logic wrap;
   assign wrap = cnt_q == half - 8'h01;
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cnt_q <= 8'h00;
         clk_in <= 1'b0;
      end
      else
      begin
         cnt_q <= (!en || wrap) ? 8'h00 : cnt_q + 8'h01;
         clk_in <= (en && wrap) ? !clk_in : clk_in && en;
      end
   end
endmodule
`default_nettype wire

// ### ccm_top_tb_top.sv
// Self-checking bench for the clock manager.
// Assumes PW shrunk to 10 and an input clock period of 64 mclk.
`timescale 1ns/100ps
`default_nettype none
module ccm_top_tb_top;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic ce = 1'b1;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [7:0] wdata = 8'h00;
   logic src_en = 1'b0;
   logic clk_in;
   logic [7:0] rdata_q;
   logic fast_edge_clock_output_q;
   logic sys_clk_q;
   logic lock_q;
   logic [7:0] rd_v;
   int mismatches = 0;
   int check_count = 0;
   int n, a, b, h;
   // Address, write value, read-back value
   localparam logic [18:0] ROWS [8] = '{{3'h0, 8'h85, 8'h85},
      {3'h1, 8'h5a, 8'h5a}, {3'h2, 8'h83, 8'h83}, {3'h3, 8'h3f, 8'h3f},
      {3'h4, 8'hf0, 8'hf0}, {3'h5, 8'h11, 8'h11}, {3'h6, 8'hff, 8'hfc},
      {3'h7, 8'h03, 8'h03}};
   // Step byte, high cycles
   localparam logic [15:0] DUTY [5] = '{16'h0710, 16'h3e0e, 16'h7820,
      16'h8022, 16'hf03e};
   always #12.5 mclk = !mclk;
   ccm_top #(.PW(10)) ccm_top_inst (.mclk(mclk), .reset_n(reset_n),
      .ce(ce), .clk_in(clk_in), .wr_en(wr_en), .rd_en(rd_en),
      .addr(addr), .wdata(wdata), .rdata_q(rdata_q),
      .fast_edge_clock_output_q(fast_edge_clock_output_q),
      .sys_clk_q(sys_clk_q), .lock_q(lock_q));
   ccm_clk_src ccm_clk_src_inst (.mclk(mclk), .reset_n(reset_n),
      .en(src_en), .half(8'h20), .clk_in(clk_in));
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [2:0] ad, input logic [7:0] d);
      @(posedge mclk);
      wr_en <= 1'b1;
      addr <= ad;
      wdata <= d;
      @(posedge mclk);
      wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] ad);
      @(posedge mclk);
      rd_en <= 1'b1;
      addr <= ad;
      @(posedge mclk);
      rd_en <= 1'b0;
      #1;
      rd_v = rdata_q;
   endtask
   function automatic logic sel(input int w);
      return w == 0 ? clk_in : w == 1 ? sys_clk_q : w == 2 ?
         fast_edge_clock_output_q : lock_q;
   endfunction
   // Bounded wait for a level, counting cycles
   task automatic wlv(input int w, input logic v, output int k);
      k = 0;
      while (sel(w) !== v)
      begin
         @(posedge mclk);
         #1;
         k++;
         if (k > 3000)
         begin
            mismatches++;
            wrap_up();
         end
      end
   endtask
   task automatic meas(input int w, output int off, output int hi);
      int k;
      wlv(0, 1'b0, k);
      wlv(0, 1'b1, k);
      wlv(w, 1'b0, off);
      wlv(w, 1'b1, k);
      off += k;
      wlv(w, 1'b0, hi);
   endtask
   initial
   begin
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      foreach (ROWS[i])
      begin
         rd(ROWS[i][18:16]);
         cmp(rd_v, 8'h00);
      end
      foreach (ROWS[i])
         wr(ROWS[i][18:16], ROWS[i][15:8]);
      foreach (ROWS[i])
      begin
         rd(ROWS[i][18:16]);
         cmp(rd_v, ROWS[i][7:0]);
      end
      $display("register test done");
      @(posedge mclk);
      wr_en <= 1'b1;
      rd_en <= 1'b1;
      addr <= 3'h3;
      wdata <= 8'h12;
      @(posedge mclk);
      wr_en <= 1'b0;
      rd_en <= 1'b0;
      #1;
      cmp(rdata_q, 8'h3f);
      @(posedge mclk);
      ce <= 1'b0;
      wr(3'h3, 8'h77);
      @(posedge mclk);
      ce <= 1'b1;
      rd(3'h3);
      cmp(rd_v, 8'h12);
      $display("port test done");
      wr(3'h0, 8'h00);
      wr(3'h2, 8'h00);
      wr(3'h7, 8'h00);
      wr(3'h5, 8'h10);
      wr(3'h6, 8'h40);
      @(posedge mclk);
      src_en <= 1'b1;
      wlv(3, 1'b1, n);
      rd(3'h6);
      cmp(rd_v, 8'h43);
      foreach (DUTY[i])
      begin
         wr(3'h4, DUTY[i][15:8]);
         repeat (2) meas(1, a, h);
         cmp(8'(h), DUTY[i][7:0]);
      end
      $display("duty test done");
      wr(3'h6, 8'h80);
      wr(3'h4, 8'h07);
      repeat (2) meas(1, a, h);
      cmp(8'(h), 8'h20);
      wr(3'h4, 8'h78);
      repeat (2) meas(1, b, h);
      cmp(8'((b - a + 64) % 64), 8'h10);
      wr(3'h6, 8'h30);
      for (int i = 0; i < 3; i++)
      begin
         wr(3'h2, 8'((1 << i) - 1));
         repeat (300) @(posedge mclk);
         wlv(2, 1'b0, a);
         wlv(2, 1'b1, a);
         wlv(2, 1'b0, b);
         wlv(2, 1'b1, h);
         cmp(8'((b + h) / 64), 8'(1 << i));
      end
      wr(3'h2, 8'h80);
      repeat (300) @(posedge mclk);
      #1;
      cmp({7'h00, fast_edge_clock_output_q}, 8'h00);
      wr(3'h6, 8'h20);
      repeat (2) meas(2, a, h);
      cmp(8'(h), 8'h20);
      $display("delay test done");
      wr(3'h6, 8'h50);
      wr(3'h0, 8'h01);
      repeat (800) @(posedge mclk);
      repeat (2) meas(1, a, h);
      cmp(8'(h), 8'h40);
      repeat (2) meas(2, a, h);
      cmp(8'(h), 8'h40);
      wr(3'h5, 8'h11);
      repeat (8) @(posedge mclk);
      #1;
      cmp({5'h00, lock_q, sys_clk_q, fast_edge_clock_output_q}, 8'h00);
      wr(3'h5, 8'h10);
      wlv(3, 1'b1, n);
      wr(3'h7, 8'h01);
      repeat (4) @(posedge mclk);
      #1;
      cmp({6'h00, lock_q, sys_clk_q}, 8'h00);
      wr(3'h7, 8'h00);
      wlv(3, 1'b1, n);
      @(posedge mclk);
      src_en <= 1'b0;
      repeat (1400) @(posedge mclk);
      #1;
      cmp({7'h00, lock_q}, 8'h00);
      @(posedge mclk);
      reset_n <= 1'b0;
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      rd(3'h4);
      cmp(rd_v, 8'h00);
      $display("mode test done");
      wrap_up();
   end
endmodule
`default_nettype wire
